// >>> src/bst_pkg.sv
// Constants and types shared by the boundary-scan test port.
package bst_pkg;

    // Controller states, coded so that neighbours in the listed order differ in one bit.
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR   = 4'h8
    } bst_state_t;

    localparam int IR_WIDTH = 3;

    // Instruction codes.
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_HIGHZ = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h2;
    localparam logic [2:0] IR_CLAMP = 3'h4;
    localparam logic [2:0] IR_PRIVATE = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;

    // Reset value and capture pattern of the instruction register.
    localparam logic [2:0] IR_RESET_VAL = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

    // Value loaded into the bypass cell at capture.
    localparam logic BYPASS_CAPTURE_VAL = 1'b0;

    // Number of consecutive high mode-select samples that always reach reset.
    localparam int RESET_TMS_ONES = 5;

    // Signal pins covered by the chain, and cell positions within one pin's group.
    localparam int PIN_COUNT = 39;
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

endpackage

// >>> src/bst_tap.sv
// Boundary-scan test access port: controller, instruction and data registers, pad muxing.
`timescale 1ns/1ps
`default_nettype none

module bst_tap
    import bst_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tmsIn,
    input wire logic tdiIn,
    output logic tdoOut,
    output logic tdoOe,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [PINS-1:0] sysOut,
    input wire logic [PINS-1:0] sysOe,
    output logic [PINS-1:0] padOut,
    output logic [PINS-1:0] padOe,
    output logic sysResetReq
);

    localparam int CELLS = PINS * CELLS_PER_PIN;

    // State clocked by the rising test clock edge.
    typedef struct packed {
        bst_state_t st;
        logic [IR_WIDTH-1:0] ir;
        logic [IR_WIDTH-1:0] inst;
        logic byp;
        logic [CELLS-1:0] bsr;
        logic [CELLS-1:0] upd;
        logic updTgl;
        logic [CELLS-1:0] cap1;
        logic [CELLS-1:0] cap2;
        logic rst1;
        logic rst2;
    } bst_tck_t;

    // State clocked by the falling test clock edge.
    typedef struct packed {
        logic oe;
        logic dout;
    } bst_neg_t;

    // State in the system clock domain.
    typedef struct packed {
        logic [2:0] mode1;
        logic [2:0] mode2;
        logic [2:0] mode3;
        logic [2:0] modeNow;
        logic tgl1;
        logic tgl2;
        logic tgl3;
        logic [CELLS-1:0] hold;
        logic [PINS-1:0] out;
        logic [PINS-1:0] oe;
        logic sysRst;
    } bst_sys_t;

    bst_tck_t t_reg;
    bst_tck_t t_next;
    bst_neg_t n_reg;
    bst_neg_t n_next;
    bst_sys_t s_reg;
    bst_sys_t s_next;

    logic [CELLS-1:0] capVec;
    logic tckRst;
    logic selBsr;
    logic isExtest;
    logic isHighz;
    logic isClamp;

    function automatic bst_state_t tap_next(input bst_state_t s, input logic m);
        bst_state_t r;
        r = s;
        case (s)
            ST_RESET: r = m ? ST_RESET : ST_IDLE;
            ST_IDLE: r = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: r = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: r = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: r = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: r = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: r = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: r = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: r = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: r = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: r = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: r = m ? ST_SEL_DR : ST_IDLE;
            default: r = ST_RESET;
        endcase
        return r;
    endfunction

    // Each pin contributes its pad level, its core output and its core enable.
    for (genvar p = 0; p < PINS; p++) begin : g_cap
        assign capVec[p*CELLS_PER_PIN+CELL_IN] = pinIn[p];
        assign capVec[p*CELLS_PER_PIN+CELL_OUT] = sysOut[p];
        assign capVec[p*CELLS_PER_PIN+CELL_OE] = sysOe[p];
    end

    assign tckRst = t_reg.rst2;
    assign isExtest = (t_reg.inst == IR_EXTEST);
    assign isHighz = (t_reg.inst == IR_HIGHZ);
    assign isClamp = (t_reg.inst == IR_CLAMP);
    // Every other code, the private one included, leaves the bypass cell in the path.
    assign selBsr = isExtest || (t_reg.inst == IR_SAMPLE);

    always_comb begin
        t_next = t_reg;
        // The power-up reset comes from the system domain, so it is synchronised first.
        t_next.rst1 = reset;
        t_next.rst2 = t_reg.rst1;
        // Pin levels are unrelated to the test clock, so they pass two test-clock flops before capture.
        t_next.cap1 = capVec;
        t_next.cap2 = t_reg.cap1;
        // The pad pull-up keeps an undriven mode select high, walking back to reset.
        t_next.st = tap_next(t_reg.st, tmsIn);
        case (t_reg.st)
            ST_RESET: begin
                t_next.ir = IR_RESET_VAL;
                t_next.inst = IR_RESET_VAL;
            end
            ST_CAP_IR: begin
                t_next.ir = IR_CAPTURE_VAL;
            end
            ST_SHIFT_IR: begin
                t_next.ir = {tdiIn, t_reg.ir[IR_WIDTH-1:1]};
            end
            ST_UPD_IR: begin
                t_next.inst = t_reg.ir;
            end
            ST_CAP_DR: begin
                if (selBsr) begin
                    t_next.bsr = t_reg.cap2;
                end else begin
                    t_next.byp = BYPASS_CAPTURE_VAL;
                end
            end
            ST_SHIFT_DR: begin
                if (selBsr) begin
                    t_next.bsr = {tdiIn, t_reg.bsr[CELLS-1:1]};
                end else begin
                    t_next.byp = tdiIn;
                end
            end
            ST_UPD_DR: begin
                if (selBsr) begin
                    t_next.upd = t_reg.bsr;
                    t_next.updTgl = ~t_reg.updTgl;
                end
            end
            default: begin
            end
        endcase
        if (tckRst) begin
            t_next.st = ST_RESET;
            t_next.inst = IR_RESET_VAL;
            // A toggle left unknown at power-up would never be seen to change.
            t_next.updTgl = 1'b0;
        end
    end

    // Plain flip-flops with no dynamic nodes, so a stopped test clock loses nothing.
    always_ff @(posedge tck) begin
        t_reg <= t_next;
    end

    always_comb begin
        n_next.oe = (t_reg.st == ST_SHIFT_IR) || (t_reg.st == ST_SHIFT_DR);
        if (t_reg.st == ST_SHIFT_IR) begin
            n_next.dout = t_reg.ir[0];
        end else if (selBsr) begin
            n_next.dout = t_reg.bsr[0];
        end else begin
            n_next.dout = t_reg.byp;
        end
        if (tckRst) begin
            n_next.oe = 1'b0;
        end
    end

    always_ff @(negedge tck) begin
        n_reg <= n_next;
    end

    assign tdoOut = n_reg.dout;
    assign tdoOe = n_reg.oe;

    always_comb begin
        s_next = s_reg;
        s_next.mode1 = {isClamp, isHighz, isExtest};
        s_next.mode2 = s_reg.mode1;
        s_next.mode3 = s_reg.mode2;
        // The decoded bits may be caught mid-change, so a mode is used only once two
        // synchronised samples agree.
        if (s_reg.mode2 == s_reg.mode3) begin
            s_next.modeNow = s_reg.mode3;
        end
        s_next.tgl1 = t_reg.updTgl;
        s_next.tgl2 = s_reg.tgl1;
        s_next.tgl3 = s_reg.tgl2;
        // The update word stays put for several test clocks after its toggle, so it is
        // safe to copy once the toggle has crossed.
        if (s_reg.tgl3 != s_reg.tgl2) begin
            s_next.hold = t_reg.upd;
        end
        for (int p = 0; p < PINS; p++) begin
            if (s_reg.modeNow[1]) begin
                s_next.out[p] = 1'b0;
                s_next.oe[p] = 1'b0;
            end else if (s_reg.modeNow[0] || s_reg.modeNow[2]) begin
                s_next.out[p] = s_reg.hold[p*CELLS_PER_PIN+CELL_OUT];
                s_next.oe[p] = s_reg.hold[p*CELLS_PER_PIN+CELL_OE];
            end else begin
                s_next.out[p] = sysOut[p];
                s_next.oe[p] = sysOe[p];
            end
        end
        s_next.sysRst = s_reg.modeNow[0] || s_reg.modeNow[1];
        if (reset) begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign padOut = s_reg.out;
    assign padOe = s_reg.oe;
    assign sysResetReq = s_reg.sysRst;

    a_reset_release: assert property (
        @(posedge tck) disable iff (tckRst)
        $fell(tckRst) |-> (t_reg.st == ST_RESET)
    ) else $error("controller not in reset when power-up reset released");

    a_tms_ones_reset: assert property (
        @(posedge tck) disable iff (tckRst)
        tmsIn [*5] |=> (t_reg.st == ST_RESET)
    ) else $error("five high mode-select samples did not reach reset");

    a_ir_capture: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_CAP_IR) |=> (t_reg.ir == IR_CAPTURE_VAL)
    ) else $error("instruction capture pattern wrong");

    a_ir_reset_ones: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_RESET) |=> (t_reg.ir == IR_RESET_VAL) && (t_reg.inst == IR_RESET_VAL)
    ) else $error("instruction not all ones after reset state");

    a_bypass_zero: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_CAP_DR) && !selBsr |=> !t_reg.byp
    ) else $error("bypass cell did not capture zero");

    a_bypass_path: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_SHIFT_DR) && !selBsr |=> (t_reg.byp == $past(tdiIn))
    ) else $error("bypass path longer than one cell");

    a_chain_shift: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_SHIFT_DR) && selBsr |=>
            (t_reg.bsr[CELLS-1] == $past(tdiIn)) && (t_reg.bsr[0] == $past(t_reg.bsr[1]))
    ) else $error("boundary chain did not shift by one");

    a_tdo_drive: assert property (
        @(posedge tck) disable iff (reset || tckRst)
        tdoOe == ((t_reg.st == ST_SHIFT_IR) || (t_reg.st == ST_SHIFT_DR))
    ) else $error("data output enabled outside a shift state");

    a_tdo_ir_bit: assert property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_SHIFT_IR) ##1 (t_reg.st == ST_SHIFT_IR) |-> (tdoOut == t_reg.ir[0])
    ) else $error("data output not the instruction bit after falling edge");

    a_highz_pads: assert property (
        @(posedge clk) disable iff (reset)
        s_reg.modeNow[1] |=> (padOe == '0) && sysResetReq
    ) else $error("pads still driven under high-impedance instruction");

    c_bypass_shift: cover property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_SHIFT_DR) && !selBsr
    );

    c_ir_update: cover property (
        @(posedge tck) disable iff (tckRst)
        (t_reg.st == ST_UPD_IR) ##1 isExtest
    );

    c_extest_pads: cover property (
        @(posedge clk) disable iff (reset)
        s_reg.modeNow[0] && (padOe != '0)
    );

endmodule

`default_nettype wire

// >>> test/bst_tester.sv
// Board-tester model that walks the test port through its states.
`timescale 1ns/1ps
`default_nettype none

module bst_tester
    import bst_pkg::*;
(
    output logic tck,
    output logic tmsIn,
    output logic tdiIn,
    input wire logic tdoOut,
    input wire logic tdoOe
);
    logic lastBit = 1'b0;

    initial begin
        tck = 1'b0;
        tmsIn = 1'b1;
        tdiIn = 1'b1;
    end

    // One test clock period; the clock rests low between calls, so it may stop at any time.
    task automatic step(input logic msel, input logic din, output logic dout);
        tmsIn = msel;
        tdiIn = din;
        #6;
        // A released line reads as the inverse of its last bit, never as stale data.
        dout = tdoOe ? tdoOut : ~lastBit;
        lastBit = dout;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask

    task automatic loadIr(input logic [2:0] code, output logic [2:0] capt);
        logic d;
        step(1'b1, 1'b1, d);
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < IR_WIDTH; i++) begin
            step(i == IR_WIDTH - 1, code[i], capt[i]);
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask

    task automatic scanDr(input int n, input logic [127:0] din, input int pauseNs,
                          output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            if (i == n / 2) begin
                #(pauseNs);
            end
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
endmodule

`default_nettype wire

// >>> test/test_boundary_scan_test_port.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none

module test_boundary_scan_test_port
    import bst_pkg::*;
;
    localparam int CELLS = PIN_COUNT * CELLS_PER_PIN;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tck, tmsIn, tdiIn, tdoOut, tdoOe, sysResetReq;
    logic [PIN_COUNT-1:0] pinIn = 39'h2a5c3e1f09;
    logic [PIN_COUNT-1:0] sysOut = 39'h13c96a5e72;
    logic [PIN_COUNT-1:0] sysOe = 39'h4b0f3d2c61;
    logic [PIN_COUNT-1:0] padOut, padOe;
    int errTotal = 0;
    int nChecks = 0;

    bst_tap #(.PINS(PIN_COUNT)) dut (.clk(clk), .reset(reset), .tck(tck), .tmsIn(tmsIn),
        .tdiIn(tdiIn), .tdoOut(tdoOut), .tdoOe(tdoOe), .pinIn(pinIn), .sysOut(sysOut),
        .sysOe(sysOe), .padOut(padOut), .padOe(padOe), .sysResetReq(sysResetReq));
    bst_tester tester (.tck(tck), .tmsIn(tmsIn), .tdiIn(tdiIn), .tdoOut(tdoOut),
        .tdoOe(tdoOe));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (errTotal == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The pause mid-shift stops the test clock to show that shift state survives.
    task automatic scenBypass();
        logic [127:0] got;
        tester.scanDr(8, 128'hb4, 700, got);
        check("bypass first bit", 128'h0, 128'(got[0]));
        check("bypass path", 128'h34, 128'(got[7:1]));
    endtask

    task automatic scenTransparent();
        repeat (8) @(posedge clk);
        check("data out enable idle", 128'h0, 128'(tdoOe));
        check("pad values", 128'(sysOut), 128'(padOut));
        check("pad enables", 128'(sysOe), 128'(padOe));
        check("system reset request", 128'h0, 128'(sysResetReq));
    endtask

    task automatic scenCodes();
        logic [2:0] codes [8] = '{IR_EXTEST, IR_HIGHZ, IR_SAMPLE, IR_CLAMP, IR_PRIVATE, IR_BYPASS,
            3'h3, 3'h5};
        logic [2:0] capt;
        logic expReq;
        foreach (codes[k]) begin
            tester.loadIr(codes[k], capt);
            repeat (8) @(posedge clk);
            expReq = (codes[k] == IR_EXTEST) || (codes[k] == IR_HIGHZ);
            check("captured instruction", 128'(IR_CAPTURE_VAL), 128'(capt));
            check("system reset request", 128'(expReq), 128'(sysResetReq));
            check("data out enable", 128'h0, 128'(tdoOe));
            if (codes[k] == IR_HIGHZ) begin
                check("highz enables", 128'h0, 128'(padOe));
                check("highz values", 128'h0, 128'(padOut));
            end
            if (codes[k] != IR_EXTEST && codes[k] != IR_SAMPLE) begin
                scenBypass();
            end
        end
    endtask

    task automatic scenSample();
        logic [127:0] pre = 128'h0015_a5c3_96e1_0f7b_2d48_c3a1_5e69_b7d2;
        logic [127:0] exp = '0;
        logic [127:0] got;
        logic [2:0] capt;
        logic [PIN_COUNT-1:0] expOut, expOe;
        for (int p = 0; p < PIN_COUNT; p++) begin
            exp[CELLS_PER_PIN*p+CELL_IN] = pinIn[p];
            exp[CELLS_PER_PIN*p+CELL_OUT] = sysOut[p];
            exp[CELLS_PER_PIN*p+CELL_OE] = sysOe[p];
            expOut[p] = pre[CELLS_PER_PIN*p+CELL_OUT];
            expOe[p] = pre[CELLS_PER_PIN*p+CELL_OE];
        end
        tester.loadIr(IR_SAMPLE, capt);
        tester.scanDr(CELLS, pre, 0, got);
        check("sampled chain", exp, got);
        check("pads during sample", 128'(sysOut), 128'(padOut));
        tester.loadIr(IR_EXTEST, capt);
        repeat (8) @(posedge clk);
        check("extest pad values", 128'(expOut), 128'(padOut));
        check("extest pad enables", 128'(expOe), 128'(padOe));
        tester.loadIr(IR_CLAMP, capt);
        repeat (8) @(posedge clk);
        check("clamp pad values", 128'(expOut), 128'(padOut));
        check("clamp pad enables", 128'(expOe), 128'(padOe));
        check("clamp reset request", 128'h0, 128'(sysResetReq));
    endtask

    // A full instruction load made while reset is held must leave bypass selected.
    task automatic scenResetHold();
        logic [2:0] capt;
        logic d;
        @(posedge clk);
        reset <= 1'b1;
        tester.step(1'b0, 1'b1, d);
        tester.loadIr(IR_EXTEST, capt);
        @(posedge clk);
        reset <= 1'b0;
        repeat (3) tester.step(1'b1, 1'b1, d);
        tester.step(1'b0, 1'b1, d);
        repeat (8) @(posedge clk);
        check("reset held request", 128'h0, 128'(sysResetReq));
        scenBypass();
    endtask

    // Five high mode-select samples from inside the data path must fall back to bypass.
    task automatic scenTmsReset();
        logic [2:0] capt;
        logic d;
        tester.loadIr(IR_EXTEST, capt);
        repeat (8) @(posedge clk);
        check("extest reset request", 128'h1, 128'(sysResetReq));
        tester.step(1'b1, 1'b1, d);
        tester.step(1'b0, 1'b1, d);
        tester.step(1'b0, 1'b1, d);
        repeat (5) tester.step(1'b1, 1'b1, d);
        tester.step(1'b0, 1'b1, d);
        repeat (8) @(posedge clk);
        check("five ones request", 128'h0, 128'(sysResetReq));
        scenBypass();
    endtask

    initial begin
        logic d;
        fork
            repeat (12) @(posedge clk);
            repeat (7) tester.step(1'b1, 1'b1, d);
        join
        reset <= 1'b0;
        repeat (3) tester.step(1'b1, 1'b1, d);
        tester.step(1'b0, 1'b1, d);
        scenTransparent();
        scenBypass();
        scenCodes();
        scenSample();
        scenResetHold();
        scenTmsReset();
        finish_test();
    end

    initial begin
        #600000;
        errTotal++;
        finish_test();
    end
endmodule

`default_nettype wire
